// ### design/cip_pkg.sv
/*
  Shared constants for the configurable inhibit pin: register offsets,
  field positions, reset values, timing counts and mode encodings.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package cip_pkg;

  // Pin function selection.
  typedef enum logic [1:0] {
    CIP_FUNC_INHIBIT = 2'b00,
    CIP_FUNC_INPUT = 2'b01,
    CIP_FUNC_OUTPUT = 2'b10
  } cip_func_t;

  // Value driven in output function.
  typedef enum logic [1:0] {
    CIP_OVAL_TRUE = 2'b00,
    CIP_OVAL_FALSE = 2'b01,
    CIP_OVAL_PWM = 2'b10
  } cip_oval_t;

  // Register byte offsets.
  localparam logic [7:0] CIP_CTRL_OFS = 8'h00;
  localparam logic [7:0] CIP_ONOFF_OFS = 8'h04;
  localparam logic [7:0] CIP_STATUS_OFS = 8'h08;
  localparam logic [7:0] CIP_PWM_PER_OFS = 8'h0c;
  localparam logic [7:0] CIP_PWM_DUTY_OFS = 8'h10;

  // Control register fields.
  localparam int CIP_CTRL_INV_BIT = 0;
  localparam int CIP_CTRL_FUNC_LSB = 1;
  localparam int CIP_CTRL_LATCH_BIT = 3;
  localparam int CIP_CTRL_OVAL_LSB = 4;

  // On/off and status fields.
  localparam int CIP_ONOFF_ON_BIT = 0;
  localparam int CIP_STAT_IN_BIT = 0;
  localparam int CIP_STAT_BLOCK_BIT = 1;
  localparam int CIP_STAT_TRIP_BIT = 2;
  localparam int CIP_STAT_OUTEN_BIT = 3;

  // Reset values.
  localparam logic [15:0] CIP_PWM_PER_RST = 16'h0064;
  localparam logic [15:0] CIP_PWM_DUTY_RST = 16'h0032;

  // Timing: least low time of a latching pulse.
  localparam int CIP_CLK_PERIOD_NS = 10;
  localparam int CIP_LATCH_MIN_US = 30;
  localparam logic [11:0] CIP_LATCH_MIN_CYC =
    12'((CIP_LATCH_MIN_US * 1000 + CIP_CLK_PERIOD_NS - 1) / CIP_CLK_PERIOD_NS);

  // Maps a logical value to a pin level and back; normal polarity is active low.
  function automatic logic cip_pol(input logic x, input logic inv);
    cip_pol = ~(x ^ inv);
  endfunction

  // True for every offset that holds a register.
  function automatic logic cip_mapped(input logic [7:0] a);
    cip_mapped = (a == CIP_CTRL_OFS) || (a == CIP_ONOFF_OFS) || (a == CIP_STATUS_OFS) ||
                 (a == CIP_PWM_PER_OFS) || (a == CIP_PWM_DUTY_OFS);
  endfunction

endpackage

// ### design/cip_sync.sv
/*
  Two-stage synchroniser for the asynchronous pin level.
  Assumes the input may change at any time relative to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cip_sync (
  input wire logic mclk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic d, // Asynchronous level.
  output logic q // Synchronised level.
);

  typedef struct packed {
    logic s1;
    logic s2;
  } cip_sync_st_t;

  cip_sync_st_t st_reg;
  cip_sync_st_t st_next;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // Resets high, the level of an unconnected pin.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= 2'b11;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule
`default_nettype wire

// ### design/cip_pwm.sv
/*
  PWM generator: period and high time in system clock cycles.
  Assumes settings are stable software registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cip_pwm (
  input wire logic mclk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic en, // Run the waveform.
  input wire logic [15:0] period, // Cycles per period.
  input wire logic [15:0] duty, // Asserted cycles per period.
  output logic wave // Logical waveform, registered.
);

  typedef struct packed {
    logic [15:0] cnt;
    logic wave;
  } cip_pwm_st_t;

  cip_pwm_st_t st_reg;
  cip_pwm_st_t st_next;

  // A zero period gives a steady deasserted output rather than a stuck counter.
  always_comb begin
    st_next = st_reg;
    if (!en || period == 16'h0000) begin
      st_next.cnt = 16'h0000;
      st_next.wave = 1'b0;
    end else begin
      if (st_reg.cnt >= period - 16'h0001) begin
        st_next.cnt = 16'h0000;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
      st_next.wave = st_reg.cnt < duty;
    end
  end

  // Counter and output register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wave = st_reg.wave;

endmodule
`default_nettype wire

// ### design/cip_top.sv
/*
  Configurable inhibit pin: one rear-connector pin acting as a level or
  latched output inhibit, a plain input, or an output (1, 0 or PWM),
  with a polarity invert. Registers are reached over APB.
  Assumes one 100 MHz clock; the pin level is asynchronous to it.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cip_top (
  input wire logic mclk, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped offset.
  input wire logic pin_in, // Pin level seen at the connector.
  output logic pin_out, // Level driven on the pin.
  output logic pin_oe, // High while the pin is driven.
  output logic out_allowed, // Instrument output may operate.
  output logic on_indicator, // On indication to the panel.
  output logic output_block_input // Level inhibit active, for the front_display.
);
  import cip_pkg::*;

  typedef struct packed {
    logic inv;
    cip_func_t func;
    logic latch;
    cip_oval_t oval;
    logic [15:0] pwm_per;
    logic [15:0] pwm_duty;
    logic on;
    logic trip;
    logic [11:0] wcnt;
    logic in_val;
    logic blk;
    logic out_en;
    logic pin_out;
    logic pin_oe;
    logic [31:0] rdata;
  } cip_top_st_t;

  cip_top_st_t st_reg;
  cip_top_st_t st_next;

  logic pin_s;
  logic pwm_wave;
  logic in_lvl;
  logic wr_acc;
  logic rd_setup;
  logic living_blk;
  logic latch_mode;
  logic trip_fire;
  logic on_wr;

  // Synchronise the pin before any decision reads it.
  cip_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(pin_in),
    .q(pin_s)
  );

  // PWM runs only while the pin is an output set to PWM.
  cip_pwm u_pwm (
    .mclk(mclk),
    .rst(rst),
    .en(st_reg.func == CIP_FUNC_OUTPUT && st_reg.oval == CIP_OVAL_PWM),
    .period(st_reg.pwm_per),
    .duty(st_reg.pwm_duty),
    .wave(pwm_wave)
  );

  // Bus strobes; a write acts only in the access phase.
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign on_wr = wr_acc && paddr == CIP_ONOFF_OFS;

  // Logical pin level: asserted means inhibit requested or input reads 1.
  assign in_lvl = cip_pol(pin_s, st_reg.inv);
  assign latch_mode = st_reg.func == CIP_FUNC_INHIBIT && st_reg.latch;

  // Idle level never blocks; the asserted level blocks while it lasts.
  assign living_blk = st_reg.func == CIP_FUNC_INHIBIT && !st_reg.latch && in_lvl;

  // Trip fires once, on the cycle the pulse reaches its least width.
  assign trip_fire = latch_mode && in_lvl && st_reg.on &&
                     st_reg.wcnt == CIP_LATCH_MIN_CYC - 12'h001;

  // Next-state logic for the whole block.
  always_comb begin
    st_next = st_reg;
    st_next.in_val = in_lvl;

    // Width counter saturates so a long pulse trips only once.
    if (latch_mode && in_lvl) begin
      if (st_reg.wcnt != CIP_LATCH_MIN_CYC) begin
        st_next.wcnt = st_reg.wcnt + 12'h001;
      end
    end else begin
      st_next.wcnt = 12'h000;
    end

    // Software clears the trip flag by writing one.
    if (wr_acc && paddr == CIP_STATUS_OFS && pwdata[CIP_STAT_TRIP_BIT]) begin
      st_next.trip = 1'b0;
    end

    // Operator on/off; only this write can switch the output on again.
    if (on_wr) begin
      st_next.on = pwdata[CIP_ONOFF_ON_BIT];
    end

    // Trip placed last so it wins over a same-cycle clear or switch-on.
    if (trip_fire) begin
      st_next.on = 1'b0;
      st_next.trip = 1'b1;
    end

    // Level inhibit forces the output to zero but leaves on set.
    st_next.blk = living_blk;
    st_next.out_en = st_next.on && !living_blk;

    // Pin drive.
    st_next.pin_oe = st_reg.func == CIP_FUNC_OUTPUT;
    case (st_reg.oval)
      CIP_OVAL_TRUE: st_next.pin_out = cip_pol(1'b1, st_reg.inv);
      CIP_OVAL_FALSE: st_next.pin_out = cip_pol(1'b0, st_reg.inv);
      CIP_OVAL_PWM: st_next.pin_out = cip_pol(pwm_wave, st_reg.inv);
      default: st_next.pin_out = 1'b1;
    endcase
    if (st_reg.func != CIP_FUNC_OUTPUT) begin
      st_next.pin_out = 1'b1;
    end

    // Configuration writes.
    if (wr_acc && paddr == CIP_CTRL_OFS) begin
      st_next.inv = pwdata[CIP_CTRL_INV_BIT];
      st_next.func = cip_func_t'(pwdata[CIP_CTRL_FUNC_LSB +: 2]);
      st_next.latch = pwdata[CIP_CTRL_LATCH_BIT];
      st_next.oval = cip_oval_t'(pwdata[CIP_CTRL_OVAL_LSB +: 2]);
    end
    if (wr_acc && paddr == CIP_PWM_PER_OFS) begin
      st_next.pwm_per = pwdata[15:0];
    end
    if (wr_acc && paddr == CIP_PWM_DUTY_OFS) begin
      st_next.pwm_duty = pwdata[15:0];
    end

    // Read data is captured in the setup cycle so prdata comes from a flop.
    if (rd_setup) begin
      st_next.rdata = 32'h0000_0000;
      case (paddr)
        CIP_CTRL_OFS: begin
          st_next.rdata[CIP_CTRL_INV_BIT] = st_reg.inv;
          st_next.rdata[CIP_CTRL_FUNC_LSB +: 2] = st_reg.func;
          st_next.rdata[CIP_CTRL_LATCH_BIT] = st_reg.latch;
          st_next.rdata[CIP_CTRL_OVAL_LSB +: 2] = st_reg.oval;
        end
        CIP_ONOFF_OFS: st_next.rdata[CIP_ONOFF_ON_BIT] = st_reg.on;
        CIP_STATUS_OFS: begin
          st_next.rdata[CIP_STAT_IN_BIT] = st_reg.in_val;
          st_next.rdata[CIP_STAT_BLOCK_BIT] = st_reg.blk;
          st_next.rdata[CIP_STAT_TRIP_BIT] = st_reg.trip;
          st_next.rdata[CIP_STAT_OUTEN_BIT] = st_reg.out_en;
        end
        CIP_PWM_PER_OFS: st_next.rdata[15:0] = st_reg.pwm_per;
        CIP_PWM_DUTY_OFS: st_next.rdata[15:0] = st_reg.pwm_duty;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; reset gives inhibit, living, normal polarity, output off.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.pin_out <= 1'b1;
      st_reg.pwm_per <= CIP_PWM_PER_RST;
      st_reg.pwm_duty <= CIP_PWM_DUTY_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave; unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~cip_mapped(paddr);
  assign prdata = st_reg.rdata;
  assign pin_out = st_reg.pin_out;
  assign pin_oe = st_reg.pin_oe;
  assign out_allowed = st_reg.out_en;
  assign on_indicator = st_reg.on;
  assign output_block_input = st_reg.blk;

  // Cycles the synchronised pin has sat at its idle level, for the restore check.
  logic [1:0] idle_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 2'b00;
    end else if (in_lvl) begin
      idle_cnt <= 2'b00;
    end else if (idle_cnt != 2'b11) begin
      idle_cnt <= idle_cnt + 2'b01;
    end
  end

  // Named steps of the inhibit behaviour; a_living_block_out, a_living_restore and a_latch_trip_off below are built from them.
  // Every check is switched off while reset is held.
  sequence s_living_on;
    st_reg.func == CIP_FUNC_INHIBIT && !st_reg.latch && st_reg.on && !on_wr;
  endsequence

  sequence s_trip_edge;
    latch_mode && st_reg.on && in_lvl && st_reg.wcnt == CIP_LATCH_MIN_CYC - 12'h001;
  endsequence

  a_pin_sync_delay: assert property (@(posedge mclk) disable iff (rst)
    $past(rst) == 1'b0 |-> pin_s == $past(pin_in, 2) || $past(rst, 2))
    else $error("Pin level not delayed by two stages.");

  a_out_true_level: assert property (@(posedge mclk) disable iff (rst)
    $past(st_reg.func) == CIP_FUNC_OUTPUT && $past(st_reg.oval) == CIP_OVAL_TRUE
    |-> pin_oe && pin_out == $past(st_reg.inv))
    else $error("Output true drives wrong level.");

  a_out_false_level: assert property (@(posedge mclk) disable iff (rst)
    $past(st_reg.func) == CIP_FUNC_OUTPUT && $past(st_reg.oval) == CIP_OVAL_FALSE
    |-> pin_oe && pin_out == !$past(st_reg.inv))
    else $error("Output false drives wrong level.");

  a_input_polarity: assert property (@(posedge mclk) disable iff (rst)
    ##1 st_reg.in_val == ($past(pin_s) ^ !$past(st_reg.inv)))
    else $error("Input value ignores polarity.");

  a_living_block_out: assert property (@(posedge mclk) disable iff (rst)
    s_living_on and in_lvl |=> !out_allowed && on_indicator && output_block_input)
    else $error("Level inhibit did not zero output with on kept.");

  a_living_restore: assert property (@(posedge mclk) disable iff (rst)
    s_living_on ##1 (s_living_on and (idle_cnt == 2'b01 && !in_lvl)) |=> out_allowed)
    else $error("Output not restored after level inhibit.");

  a_idle_no_effect: assert property (@(posedge mclk) disable iff (rst)
    st_reg.func == CIP_FUNC_INHIBIT && !st_reg.latch && !in_lvl |=> !output_block_input)
    else $error("Idle pin level blocked the output.");

  a_latch_trip_off: assert property (@(posedge mclk) disable iff (rst)
    s_trip_edge |=> !on_indicator && !out_allowed ##0 st_reg.trip)
    else $error("Latched pulse did not switch output off.");

  a_latch_short_pulse: assert property (@(posedge mclk) disable iff (rst)
    latch_mode && st_reg.on && !on_wr && st_reg.wcnt < CIP_LATCH_MIN_CYC - 12'h001
    |=> on_indicator)
    else $error("Pulse below least width tripped the output.");

  a_latch_stays_off: assert property (@(posedge mclk) disable iff (rst)
    latch_mode && !st_reg.on && !on_wr |=> !on_indicator)
    else $error("Output came back on without an on write.");

  a_pwm_drive: assert property (@(posedge mclk) disable iff (rst)
    $past(st_reg.func) == CIP_FUNC_OUTPUT && $past(st_reg.oval) == CIP_OVAL_PWM
    |-> pin_oe && pin_out == ($past(pwm_wave) ^ !$past(st_reg.inv)))
    else $error("PWM waveform not driven on the pin.");

  a_pin_released: assert property (@(posedge mclk) disable iff (rst)
    $past(st_reg.func) != CIP_FUNC_OUTPUT |-> !pin_oe && pin_out)
    else $error("Pin driven outside the output function.");

  a_inv_living_block: assert property (@(posedge mclk) disable iff (rst)
    st_reg.func == CIP_FUNC_INHIBIT && !st_reg.latch && st_reg.inv && pin_s |=> output_block_input)
    else $error("Inverted high level did not block the output.");

  a_latch_no_block: assert property (@(posedge mclk) disable iff (rst)
    latch_mode |=> !output_block_input)
    else $error("Latched mode raised the level inhibit.");

  a_trip_needs_width: assert property (@(posedge mclk) disable iff (rst)
    $rose(st_reg.trip) |-> $past(in_lvl) && $past(st_reg.wcnt) == CIP_LATCH_MIN_CYC - 12'h001)
    else $error("Trip set before the pulse reached its least width.");

endmodule
`default_nettype wire

// ### dv/cip_ext_model.sv
/*
  External controller wired to the pin: a pull-up holds the released wire
  high, and the controller can hold it low or send one low pulse.
  Assumes its requests change only right after an mclk rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cip_ext_model (
  input wire logic mclk, // System clock.
  input wire logic hold_low, // Hold the pin low.
  input wire logic pulse_go, // Start one low pulse.
  input wire logic [15:0] pulse_cyc, // Pulse low time in cycles.
  input wire logic pin_out, // Level the block drives.
  input wire logic pin_oe, // Block drives the pin.
  output logic pin_lvl // Resolved wire level.
);
  logic [15:0] left = 16'h0000;

  // The low phase lasts the full requested count, so a short one can be sent too.
  always @(posedge mclk) begin
    if (pulse_go) begin
      left <= pulse_cyc;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end

  // The pull-up wins only when nobody drives, so an open pin reads high.
  assign pin_lvl = pin_oe ? pin_out : ((hold_low || left != 16'h0000) ? 1'b0 : 1'b1);
endmodule
`default_nettype wire

// ### dv/cip_top_tb.sv
/*
  Self-checking bench for the inhibit pin: reset and bus error cases, table of
  pin modes, then latching, timing, PWM and mid-run reset cases by hand.
  Assumes the external controller model and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`default_nettype none
module cip_top_tb;
  import cip_pkg::*;

  // Row layout: control value, then low, pin level, drive, allowed, block, input value.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] pad;
    logic low, po, oe, oa, blk, iv;
  } cip_row_t;

  logic mclk, rst, psel, penable, pwrite, pin_in, pin_out, pin_oe, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic out_allowed, on_indicator, output_block_input, er, hold_low, pulse_go;
  logic [15:0] pulse_cyc;
  logic [7:0] cnt;
  int error_cnt, n_compared, cycles;
  cip_row_t rows [11] = '{16'h0014, 16'h0032, 16'h0014, 16'h0112, 16'h0134, 16'h0235,
    16'h0334, 16'h040c, 16'h051c, 16'h141c, 16'h150c};

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

  cip_top uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .out_allowed(out_allowed),
    .on_indicator(on_indicator), .output_block_input(output_block_input));

  cip_ext_model ext (.mclk(mclk), .hold_low(hold_low), .pulse_go(pulse_go),
    .pulse_cyc(pulse_cyc), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_in));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One APB transfer; entered right after an edge, leaves one idle cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic pulse(input logic [15:0] n);
    pulse_cyc <= n;
    pulse_go <= 1'b1;
    @(posedge mclk);
    pulse_go <= 1'b0;
    cyc(3100);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang is cut short well beyond the roughly 6600 cycles the run needs.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {rst, psel, penable, pwrite, hold_low, pulse_go} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    pulse_cyc = 16'h0000;
    cyc(20);
    `CHK({pin_out, pin_oe, out_allowed, on_indicator}, 4'h8)
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, CIP_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, CIP_PWM_PER_OFS, 32'h0);
    `CHK(rd, {16'h0, CIP_PWM_PER_RST})
    apb(1'b0, CIP_PWM_DUTY_OFS, 32'h0);
    `CHK(rd, {16'h0, CIP_PWM_DUTY_RST})
    apb(1'b0, 8'h14, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    // Mode table: every function and polarity, output values 1 and 0, with the output on.
    foreach (rows[i]) begin
      apb(1'b1, CIP_CTRL_OFS, {24'h0, rows[i].ctrl});
      apb(1'b1, CIP_ONOFF_OFS, 32'h1);
      hold_low <= rows[i].low;
      cyc(6);
      `CHK({pin_out, pin_oe}, {rows[i].po, rows[i].oe})
      `CHK({out_allowed, output_block_input}, {rows[i].oa, rows[i].blk})
      `CHK(on_indicator, 1'b1)
      apb(1'b0, CIP_STATUS_OFS, 32'h0);
      `CHK({rd[CIP_STAT_OUTEN_BIT], rd[CIP_STAT_BLOCK_BIT]}, {rows[i].oa, rows[i].blk})
      if (rows[i].ctrl[2:1] == 2'b01) begin
        `CHK(rd[CIP_STAT_IN_BIT], rows[i].iv)
      end
    end
    hold_low <= 1'b0;
    // Latched mode: a short pulse is ignored, a full one trips and stays tripped.
    apb(1'b1, CIP_CTRL_OFS, 32'h8);
    apb(1'b1, CIP_ONOFF_OFS, 32'h1);
    pulse(16'd2990);
    `CHK(on_indicator, 1'b1)
    pulse(16'd3010);
    `CHK({on_indicator, out_allowed}, 2'b00)
    apb(1'b0, CIP_STATUS_OFS, 32'h0);
    `CHK(rd[CIP_STAT_TRIP_BIT], 1'b1)
    apb(1'b1, CIP_STATUS_OFS, 32'h4);
    apb(1'b1, CIP_ONOFF_OFS, 32'h1);
    cyc(2);
    `CHK(on_indicator, 1'b1)
    apb(1'b0, CIP_STATUS_OFS, 32'h0);
    `CHK({rd[CIP_STAT_TRIP_BIT], rd[CIP_STAT_OUTEN_BIT]}, 2'b01)
    // Level inhibit reaches the outputs three cycles later: two synchroniser stages, then the state register.
    apb(1'b1, CIP_CTRL_OFS, 32'h0);
    cyc(4);
    hold_low <= 1'b1;
    cyc(2);
    #1 `CHK(output_block_input, 1'b0)
    @(posedge mclk);
    #1 `CHK(output_block_input, 1'b1)
    @(posedge mclk);
    hold_low <= 1'b0;
    // PWM of period 10 and duty 3: 30 low pin cycles in any 100.
    apb(1'b1, CIP_PWM_PER_OFS, 32'd10);
    apb(1'b1, CIP_PWM_DUTY_OFS, 32'd3);
    apb(1'b1, CIP_CTRL_OFS, 32'h24);
    cyc(20);
    cnt = 8'h00;
    repeat (100) begin
      @(posedge mclk);
      #1 if (pin_in === 1'b0) cnt++;
    end
    `CHK(cnt, 8'd30)
    // Reset in mid-run, with the pin driving PWM, returns the pin, on, allowed and block outputs, control and PWM period to their defaults.
    @(posedge mclk);
    rst <= 1'b1;
    cyc(3);
    `CHK({pin_out, pin_oe, out_allowed, on_indicator, output_block_input}, 5'h10)
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, CIP_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, CIP_PWM_PER_OFS, 32'h0);
    `CHK(rd, {16'h0, CIP_PWM_PER_RST})
    summarize();
  end
endmodule
`default_nettype wire
